// file: rtl/cca_array.sv
// Counter array with five capture/compare modules, watchdog and AXI4-Lite registers.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module cca_array (
  input wire logic aclk,
  input wire logic aresetn,
  input wire cca_pkg::cca_axi_req_t axi_req,
  output cca_pkg::cca_axi_rsp_t axi_rsp,
  input wire logic [cca_pkg::NUM_MOD-1:0] module_io_pin_i,
  output logic [cca_pkg::NUM_MOD-1:0] module_io_pin_o,
  output logic [cca_pkg::NUM_MOD-1:0] module_io_pin_oe,
  input wire logic eci_pin_i,
  input wire logic timer0_ovf_i,
  input wire logic ext_div8_tick_i,
  input wire logic cpu_idle_i,
  output logic irq_req_o,
  output logic wdt_reset_o
);
  import cca_pkg::*;

  cca_state_t q;
  cca_state_t d;
  cca_mode_t m;
  logic wr_go;
  logic we;
  logic [7:0] wa;
  logic [7:0] wd;
  logic wdt_en;
  logic run;
  logic tick;
  logic presc_wrap;
  logic [3:0] presc_last;
  logic [15:0] cnt_n;
  logic lo_ovf;
  logic full_ovf;
  logic force_rst;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] rd_val;
  logic rise;
  logic fall;
  logic match16;
  logic match8;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign axi_rsp.awready = q.awready;
  assign axi_rsp.wready = q.wready;
  assign axi_rsp.bvalid = q.bvalid;
  assign axi_rsp.bresp = q.bresp;
  assign axi_rsp.arready = q.arready;
  assign axi_rsp.rvalid = q.rvalid;
  assign axi_rsp.rdata = {24'h000000, q.rdata};
  assign axi_rsp.rresp = q.rresp;
  assign module_io_pin_o = q.pin;
  assign module_io_pin_oe = q.oe;
  assign irq_req_o = q.irq;
  assign wdt_reset_o = q.wdt_rst;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    m = '0;
    rise = 1'b0;
    fall = 1'b0;
    match16 = 1'b0;
    match8 = 1'b0;
    force_rst = 1'b0;
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    rd_val = 8'h00;
    presc_last = 4'h0;
    tick = 1'b0;
    wdt_en = q.amode.watchdog_enable | q.amode.watchdog_lock; // [RULE16] [RULE24]

    // Pin and external clock synchronisers.
    d.sync1 = module_io_pin_i; // [RULE25]
    d.sync2 = q.sync1; // [RULE25]
    d.prev = q.sync2;
    d.eci_s1 = eci_pin_i;
    d.eci_s2 = q.eci_s1;
    d.eci_prev = q.eci_s2;

    // Write channel: address and data are taken in either order.
    if (axi_req.awvalid && q.awready)
    begin
      d.awready = 1'b0;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.wready)
    begin
      d.wready = 1'b0;
      d.wdata = axi_req.wdata[7:0];
      d.wstrb0 = axi_req.wstrb[0];
    end
    wr_go = !q.awready && !q.wready && !q.bvalid;
    wa = q.awaddr;
    wd = q.wdata;
    if (wa == OFF_CTRL || wa == OFF_AMODE || wa == OFF_CNT_LO || wa == OFF_CNT_HI)
    begin
      wr_hit = 1'b1;
    end
    for (int i = 0; i < NUM_MOD; i++)
    begin
      if (wa == mod_addr(i, SUB_MODE) || wa == mod_addr(i, SUB_CMP_LO)
          || wa == mod_addr(i, SUB_CMP_HI))
      begin
        wr_hit = 1'b1;
      end
    end
    we = wr_go && q.wstrb0 && wr_hit;
    if (wr_go)
    begin
      d.bvalid = 1'b1;
      d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && axi_req.bready)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // Register writes; hardware events below are applied later so they win, except the counter tick, which a counter byte write suppresses.
    if (we)
    begin
      if (wa == OFF_CTRL)
      begin
        d.ovf_flag = wd[CTRL_OVF_BIT];
        d.run_sw = wd[CTRL_RUN_BIT]; // [RULE18]
        d.flag = wd[NUM_MOD-1:0];
        force_rst = wdt_en && wd[WDT_MOD]; // [RULE23]
      end
      if (wa == OFF_AMODE)
      begin
        if (wdt_en)
        begin
          // Timebase and idle control are frozen while the watchdog runs.
          d.amode.watchdog_enable = wd[6]; // [RULE17]
          d.amode.watchdog_lock = q.amode.watchdog_lock | wd[5]; // [RULE24]
          d.amode.overflow_irq_enable = wd[0];
        end
        else
        begin
          d.amode = wd;
          d.amode.unused = 1'b0;
        end
      end
      if (wa == OFF_CNT_LO && !wdt_en)
      begin
        d.cnt[7:0] = wd; // [RULE17]
      end
      if (wa == OFF_CNT_HI && !wdt_en)
      begin
        d.cnt[15:8] = wd; // [RULE17]
      end
      for (int i = 0; i < NUM_MOD; i++)
      begin
        if (wa == mod_addr(i, SUB_MODE) && !(i == WDT_MOD && wdt_en))
        begin
          d.mode[i] = wd; // [RULE17]
        end
        if (wa == mod_addr(i, SUB_CMP_LO))
        begin
          d.cmp_lo[i] = wd;
          d.mode[i].comparator_enable = 1'b0; // [RULE6]
        end
        if (wa == mod_addr(i, SUB_CMP_HI))
        begin
          if (i == WDT_MOD && wdt_en)
          begin
            d.cmp_hi[i] = 8'(q.cnt[15:8] + q.cmp_lo[WDT_MOD]); // [RULE20] [RULE21]
          end
          else
          begin
            d.cmp_hi[i] = wd;
            d.mode[i].comparator_enable = 1'b1; // [RULE6]
          end
        end
      end
    end

    // Read channel; reading the low counter byte latches the high byte.
    unique case (axi_req.araddr)
      OFF_CTRL:
      begin
        rd_hit = 1'b1;
        rd_val = {q.ovf_flag, q.run_sw, 1'b0, q.flag}; // [RULE18]
      end
      OFF_AMODE:
      begin
        rd_hit = 1'b1;
        rd_val = q.amode;
      end
      OFF_CNT_LO:
      begin
        rd_hit = 1'b1;
        rd_val = q.cnt[7:0];
      end
      OFF_CNT_HI:
      begin
        rd_hit = 1'b1;
        rd_val = q.snap;
      end
      default:
      begin
        for (int i = 0; i < NUM_MOD; i++)
        begin
          if (axi_req.araddr == mod_addr(i, SUB_MODE))
          begin
            rd_hit = 1'b1;
            rd_val = q.mode[i];
          end
          if (axi_req.araddr == mod_addr(i, SUB_CMP_LO))
          begin
            rd_hit = 1'b1;
            rd_val = q.cmp_lo[i];
          end
          if (axi_req.araddr == mod_addr(i, SUB_CMP_HI))
          begin
            rd_hit = 1'b1;
            rd_val = q.cmp_hi[i];
          end
        end
      end
    endcase
    if (axi_req.arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (axi_req.araddr == OFF_CNT_LO)
      begin
        d.snap = q.cnt[15:8];
      end
    end
    if (q.rvalid && axi_req.rready)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // Counter timebase. The watchdog keeps the counter running whatever the run bit says.
    run = (q.run_sw | wdt_en) && !(q.amode.idle_suspend && cpu_idle_i); // [RULE17] [RULE18]
    unique case (q.amode.timebase_select)
      TB_DIV12: presc_last = DIV12_LAST;
      TB_DIV4: presc_last = DIV4_LAST;
      default: presc_last = 4'h0;
    endcase
    presc_wrap = q.presc >= presc_last;
    unique case (q.amode.timebase_select)
      TB_DIV12, TB_DIV4, TB_SYS: tick = run && presc_wrap;
      TB_T0: tick = run && timer0_ovf_i;
      TB_ECI: tick = run && q.eci_prev && !q.eci_s2;
      TB_EXT8: tick = run && ext_div8_tick_i;
      default: tick = 1'b0;
    endcase
    if (run)
    begin
      d.presc = presc_wrap ? 4'h0 : 4'(q.presc + 4'h1);
    end
    cnt_n = 16'(q.cnt + 16'h0001);
    lo_ovf = tick && q.cnt[7:0] == 8'hFF;
    full_ovf = tick && q.cnt == 16'hFFFF;
    if (tick && !(we && (wa == OFF_CNT_LO || wa == OFF_CNT_HI) && !wdt_en))
    begin
      d.cnt = cnt_n;
    end
    if (full_ovf)
    begin
      d.ovf_flag = 1'b1;
    end

    // Capture/compare modules.
    for (int i = 0; i < NUM_MOD; i++)
    begin
      m = d.mode[i];
      rise = q.sync2[i] && !q.prev[i];
      fall = !q.sync2[i] && q.prev[i];
      d.oe[i] = (m.toggle_enable | m.pulse_mod_enable) && !(i == WDT_MOD && wdt_en);
      if (!(i == WDT_MOD && wdt_en))
      begin
        if (!(m.match_flag_enable | m.toggle_enable | m.pulse_mod_enable)
            && ((m.capture_rise_sel && rise) || (m.capture_fall_sel && fall))) // [RULE2]
        begin
          d.cmp_lo[i] = q.cnt[7:0]; // [RULE1]
          d.cmp_hi[i] = q.cnt[15:8]; // [RULE1]
          d.flag[i] = 1'b1; // [RULE3]
        end
        if (m.pulse_mod_enable && !m.toggle_enable && !m.comparator_enable)
        begin
          d.pin[i] = 1'b0; // [RULE13]
        end
        else if (tick && m.pulse_mod_enable && !m.toggle_enable && m.wide_pulse_select)
        begin
          match16 = cnt_n == {d.cmp_hi[i], d.cmp_lo[i]};
          if (full_ovf)
          begin
            d.pin[i] = 1'b0; // [RULE14]
          end
          if (match16)
          begin
            d.pin[i] = 1'b1; // [RULE14]
            d.flag[i] = d.flag[i] | m.match_flag_enable;
          end
        end
        else if (tick && m.pulse_mod_enable && !m.toggle_enable)
        begin
          if (lo_ovf)
          begin
            d.cmp_lo[i] = d.cmp_hi[i]; // [RULE12]
            d.pin[i] = 1'b0; // [RULE11]
          end
          match8 = cnt_n[7:0] == d.cmp_lo[i];
          if (match8)
          begin
            d.pin[i] = 1'b1; // [RULE11]
            d.flag[i] = d.flag[i] | m.match_flag_enable;
          end
        end
        else if (tick && m.pulse_mod_enable && m.toggle_enable && m.comparator_enable) // [RULE10]
        begin
          // A zero step wraps the low byte fully, giving a 256-tick half period.
          match8 = cnt_n[7:0] == d.cmp_lo[i];
          if (match8)
          begin
            d.pin[i] = !q.pin[i]; // [RULE9]
            d.cmp_lo[i] = 8'(d.cmp_lo[i] + d.cmp_hi[i]); // [RULE9] [RULE10]
          end
        end
        else if (tick && m.comparator_enable && m.match_flag_enable)
        begin
          match16 = cnt_n == {d.cmp_hi[i], d.cmp_lo[i]};
          if (match16)
          begin
            d.flag[i] = 1'b1; // [RULE5]
            if (m.toggle_enable)
            begin
              d.pin[i] = !q.pin[i]; // [RULE8]
            end
          end
        end
      end
    end

    // Watchdog reset comes at the low byte overflow that sees the high bytes equal.
    d.wdt_rst = wdt_en && ((lo_ovf && q.cmp_hi[WDT_MOD] == q.cnt[15:8]) || force_rst); // [RULE19] [RULE22] [RULE23]

    d.irq = |(d.flag & {d.mode[4].module_irq_enable, d.mode[3].module_irq_enable,
      d.mode[2].module_irq_enable, d.mode[1].module_irq_enable,
      d.mode[0].module_irq_enable}) || (d.ovf_flag && d.amode.overflow_irq_enable); // [RULE3] [RULE5]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : cca_array

`default_nettype wire

// file: rtl/cca_pkg.sv
// Package with constants and types for the five-module counter compare array.
//
// Behaviour
// [RULE1] Selected pin edge in capture mode copies the 16-bit counter into compare bytes.
// [RULE2] Rise select, fall select, or both pick which pin edge triggers capture.
// [RULE3] Each capture sets the event flag; only software clears it; irq if enabled.
// [RULE4] Outside source holds each pin level at least two system clocks.
// [RULE5] Comparator and match enables make a 16-bit counter match set the flag.
// [RULE6] Writing compare low clears comparator enable; writing compare high sets it.
// [RULE7] Software writes compare low before compare high.
// [RULE8] Toggle, match and comparator enables invert the pin on each 16-bit match.
// [RULE9] Square wave: low byte match toggles pin and adds high byte to low byte.
// [RULE10] Comparator, toggle and pulse enables select square wave; high 0x00 means 256.
// [RULE11] 8-bit PWM sets pin on low byte match, clears it on low byte overflow.
// [RULE12] 8-bit PWM reloads compare low from compare high at each low byte rollover.
// [RULE13] Any PWM mode with comparator enable clear holds the pin low.
// [RULE14] 16-bit PWM sets pin on 16-bit match, clears it on counter overflow.
// [RULE15] Software paces varying 16-bit duty writes with enabled match interrupts.
// [RULE16] Watchdog enable or lock makes module 4 the watchdog; enabled after reset.
// [RULE17] Watchdog forces counter on, blocks counter, timebase, idle and module 4 mode writes.
// [RULE18] Watchdog ignores run bit writes for running; run bit reads software value.
// [RULE19] Enabled watchdog resets system when module 4 high byte matches counter high.
// [RULE20] Writing module 4 high byte reloads it with counter high plus offset.
// [RULE21] Timeout equals 256 times offset plus 256 minus counter low at update.
// [RULE22] Watchdog reset fires at low byte overflow while high bytes match.
// [RULE23] Writing 1 to module 4 event flag with watchdog on forces reset.
// [RULE24] Lock prevents disabling until reset; without lock clearing enable disables.
// [RULE25] Each pin passes two flip-flops before edge detection.
package cca_pkg;

  localparam int NUM_MOD = 5;
  localparam int WDT_MOD = 4;
  localparam int ADDR_W = 8;

  // Register byte addresses on the bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AMODE = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0C;
  localparam logic [7:0] MOD_BASE = 8'h10;
  localparam logic [7:0] MOD_STRIDE = 8'h10;
  localparam logic [7:0] SUB_MODE = 8'h00;
  localparam logic [7:0] SUB_CMP_LO = 8'h04;
  localparam logic [7:0] SUB_CMP_HI = 8'h08;

  // Control register bit positions; event flags sit in bits 4..0.
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;

  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TB_DIV12 = 3'b000,
    TB_DIV4 = 3'b001,
    TB_T0 = 3'b010,
    TB_ECI = 3'b011,
    TB_SYS = 3'b100,
    TB_EXT8 = 3'b101
  } cca_tb_t;

  typedef struct packed {
    logic wide_pulse_select;
    logic comparator_enable;
    logic capture_rise_sel;
    logic capture_fall_sel;
    logic match_flag_enable;
    logic toggle_enable;
    logic pulse_mod_enable;
    logic module_irq_enable;
  } cca_mode_t;

  typedef struct packed {
    logic idle_suspend;
    logic watchdog_enable;
    logic watchdog_lock;
    logic unused;
    logic [2:0] timebase_select;
    logic overflow_irq_enable;
  } cca_amode_t;

  localparam cca_amode_t AMODE_RST = 8'h40;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cca_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cca_axi_rsp_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [15:0] cnt;
    logic [7:0] snap;
    logic [3:0] presc;
    logic ovf_flag;
    logic run_sw;
    cca_amode_t amode;
    cca_mode_t [NUM_MOD-1:0] mode;
    logic [NUM_MOD-1:0][7:0] cmp_lo;
    logic [NUM_MOD-1:0][7:0] cmp_hi;
    logic [NUM_MOD-1:0] flag;
    logic [NUM_MOD-1:0] pin;
    logic [NUM_MOD-1:0] oe;
    logic [NUM_MOD-1:0] sync1;
    logic [NUM_MOD-1:0] sync2;
    logic [NUM_MOD-1:0] prev;
    logic eci_s1;
    logic eci_s2;
    logic eci_prev;
    logic irq;
    logic wdt_rst;
  } cca_state_t;

  localparam cca_state_t STATE_RST = '{
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    amode: AMODE_RST,
    default: '0
  };

  function automatic logic [7:0] mod_addr(input int idx, input logic [7:0] sub);
    logic [7:0] base;
    base = 8'(MOD_BASE + 8'(idx) * MOD_STRIDE);
    return 8'(base + sub);
  endfunction : mod_addr

endpackage : cca_pkg

// file: tb/cca_array_monitor.sv
// Port checker for the counter compare array.
`timescale 1ns/10ps
`default_nettype none

module cca_array_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cca_pkg::cca_axi_req_t axi_req,
  input wire cca_pkg::cca_axi_rsp_t axi_rsp,
  input wire logic [cca_pkg::NUM_MOD-1:0] module_io_pin_oe,
  input wire logic irq_req_o,
  input wire logic wdt_reset_o
);
  import cca_pkg::*;
  // A forced watchdog reset comes soon after a write; a natural one needs 256 slow ticks.
  localparam int WDT_MIN = 3060;
  logic [15:0] rcyc_q;
  logic [3:0] wcyc_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rcyc_q <= '0;
      wcyc_q <= 4'hF;
    end
    else
    begin
      rcyc_q <= (rcyc_q == 16'hFFFF) ? rcyc_q : rcyc_q + 16'h1;
      wcyc_q <= (axi_req.awvalid && axi_rsp.awready) ? 4'h0 :
        ((wcyc_q == 4'hF) ? wcyc_q : wcyc_q + 4'h1);
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write answer late");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_resp_once: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  a_rdata_once: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read data repeated");
  a_ready_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("ready while response pending");
  a_wdt_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("watchdog reset longer than one cycle");
  a_wdt_timeout: assert property (wdt_reset_o |-> rcyc_q >= WDT_MIN || wcyc_q < 4'h8)
    else $error("watchdog reset too early");
  a_reset_quiet: assert property ($rose(aresetn) |-> module_io_pin_oe == '0 && !irq_req_o
    && !wdt_reset_o) else $error("outputs active out of reset");
endmodule : cca_array_monitor

bind cca_array cca_array_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .module_io_pin_oe(module_io_pin_oe), .irq_req_o(irq_req_o),
  .wdt_reset_o(wdt_reset_o));
`default_nettype wire

// file: tb/cca_pin_model.sv
// Outside sources that drive the module pins.
`timescale 1ns/10ps
`default_nettype none

module cca_pin_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cca_pkg::NUM_MOD-1:0] want,
  output logic [cca_pkg::NUM_MOD-1:0] lvl
);
  import cca_pkg::*;
  // A new level waits until the old one has stood three clocks.
  logic [1:0] hold_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lvl <= '0;
      hold_q <= 2'h0;
    end
    else if (want != lvl && hold_q >= 2'h2)
    begin
      lvl <= want;
      hold_q <= 2'h0;
    end
    else
      hold_q <= (hold_q == 2'h3) ? hold_q : hold_q + 2'h1;
  end
endmodule : cca_pin_model
`default_nettype wire

// file: tb/cca_array_tb.sv
// Self-checking testbench for the counter compare array.
`timescale 1ns/10ps
`default_nettype none

module cca_array_tb;
  import cca_pkg::*;
  logic aclk;
  logic aresetn;
  cca_axi_req_t req;
  cca_axi_rsp_t rsp;
  logic [NUM_MOD-1:0] pin_i;
  logic [NUM_MOD-1:0] pin_o;
  logic [NUM_MOD-1:0] pin_oe;
  logic [NUM_MOD-1:0] want;
  logic [NUM_MOD-1:0] ext_lvl;
  logic irq;
  logic wdt;
  logic [1:0] bresp_v;
  logic [7:0] sel [3] = '{8'h21, 8'h11, 8'h31};
  logic [7:0] hv [2] = '{8'h10, 8'h00};
  int exp_r [3] = '{8'h10, 8'h10, 8'h12};
  int exp_f [3] = '{8'h10, 8'h21, 8'h22};
  int per [2] = '{16, 256};
  int fails = 0;
  int compares = 0;
  int since_rst = 0;
  int wdt_cnt = 0;
  int wdt_at = 0;
  int n;
  int c0;

  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);

  cca_array DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .module_io_pin_i(pin_i), .module_io_pin_o(pin_o), .module_io_pin_oe(pin_oe),
    .eci_pin_i(1'b0), .timer0_ovf_i(1'b0), .ext_div8_tick_i(1'b0), .cpu_idle_i(1'b0),
    .irq_req_o(irq), .wdt_reset_o(wdt));
  cca_pin_model PART (.aclk(aclk), .aresetn(aresetn), .want(want), .lvl(ext_lvl));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    since_rst <= aresetn ? since_rst + 1 : 0;
    if (wdt === 1'b1)
    begin
      wdt_cnt <= wdt_cnt + 1;
      wdt_at <= since_rst;
    end
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // A wait that runs out of its bound ends the run as a failure.
  task automatic bound(inout int k, input int lim);
    k++;
    if (k > lim)
    begin
      fails++;
      close_out();
    end
  endtask : bound

  function automatic logic [7:0] ma(input int m, input logic [7:0] sub);
    return 8'(MOD_BASE + 8'(m) * MOD_STRIDE + sub);
  endfunction : ma

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_t;
    logic w_t;
    logic b_t;
    int k;
    k = 0;
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'hF,
      bready: 1'b1, default: '0};
    do
    begin
      @(negedge aclk);
      aw_t = rsp.awready;
      w_t = rsp.wready;
      b_t = rsp.bvalid;
      bresp_v = rsp.bresp;
      @(posedge aclk);
      if (aw_t)
        req.awvalid <= 1'b0;
      if (w_t)
        req.wvalid <= 1'b0;
      bound(k, 200);
    end
    while (b_t !== 1'b1);
    // Ready stays up after the answer, so a following call sets each signal once per step.
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic ar_t;
    logic r_t;
    logic [7:0] d;
    int k;
    k = 0;
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do
    begin
      @(negedge aclk);
      ar_t = rsp.arready;
      r_t = rsp.rvalid;
      d = rsp.rdata[7:0];
      @(posedge aclk);
      if (ar_t)
        req.arvalid <= 1'b0;
      bound(k, 200);
    end
    while (r_t !== 1'b1);
    chk(what, {8'h00, d}, {8'h00, exp});
  endtask : rdc

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic wait_flip(input int idx, output int took);
    logic s;
    took = 1;
    @(negedge aclk);
    s = pin_o[idx];
    do
    begin
      @(negedge aclk);
      bound(took, 600);
    end
    while (pin_o[idx] === s);
    @(posedge aclk);
  endtask : wait_flip

  task automatic hi_count(input int idx, output int h);
    h = 0;
    repeat (256)
    begin
      @(negedge aclk);
      h += int'(pin_o[idx] === 1'b1);
    end
    @(posedge aclk);
  endtask : hi_count

  initial
  begin
    req = '0;
    want = '0;
    aresetn = 1'b0;
    do_reset();
    rdc("ctrl", OFF_CTRL, 8'h00);
    rdc("array mode", OFF_AMODE, 8'h40);
    rdc("unmapped", 8'hF0, 8'h00);
    n = 0;
    while (wdt_cnt == 0)
    begin
      @(posedge aclk);
      bound(n, 4000);
    end
    chk("wdt timeout", 16'(wdt_at >= 3060 && wdt_at <= 3090), 16'h1);
    do_reset();
    wr(OFF_CNT_HI, 8'h77);
    rdc("cnt lo", OFF_CNT_LO, 8'h00);
    rdc("cnt hi blocked", OFF_CNT_HI, 8'h00);
    wr(ma(4, SUB_CMP_LO), 8'h01);
    wr(ma(4, SUB_CMP_HI), 8'h55);
    rdc("wdt update", ma(4, SUB_CMP_HI), 8'h01);
    wr(OFF_AMODE, 8'h20);
    rdc("locked", OFF_AMODE, 8'h20);
    wr(OFF_AMODE, 8'h00);
    rdc("lock holds", OFF_AMODE, 8'h20);
    c0 = wdt_cnt;
    wr(OFF_CTRL, 8'h10);
    repeat (4) @(posedge aclk);
    chk("forced wdt", 16'(wdt_cnt - c0), 16'h1);
    do_reset();
    wr(OFF_AMODE, 8'h08);
    rdc("timebase frozen", OFF_AMODE, 8'h00);
    wr(OFF_AMODE, 8'h08);
    rdc("timebase set", OFF_AMODE, 8'h08);
    wr(8'hF0, 8'h00);
    chk("unmapped resp", {14'h0, bresp_v}, {14'h0, RESP_SLVERR});
    wr(OFF_CNT_LO, 8'h5A);
    for (int k = 0; k < 3; k++)
    begin
      wr(ma(0, SUB_MODE), sel[k]);
      wr(OFF_CNT_HI, 8'(8'h10 + k));
      want[0] <= 1'b1;
      repeat (8) @(posedge aclk);
      rdc("cap rise", ma(0, SUB_CMP_HI), 8'(exp_r[k]));
      wr(OFF_CNT_HI, 8'(8'h20 + k));
      want[0] <= 1'b0;
      repeat (8) @(posedge aclk);
      rdc("cap fall", ma(0, SUB_CMP_HI), 8'(exp_f[k]));
    end
    rdc("cap lo", ma(0, SUB_CMP_LO), 8'h5A);
    chk("irq", {15'h0, irq}, 16'h1);
    rdc("flag", OFF_CTRL, 8'h01);
    wr(OFF_CTRL, 8'h00);
    chk("irq clear", {15'h0, irq}, 16'h0);
    wr(ma(1, SUB_MODE), 8'h4C);
    wr(ma(1, SUB_CMP_LO), 8'h00);
    rdc("ecom off", ma(1, SUB_MODE), 8'h0C);
    wr(ma(1, SUB_CMP_HI), 8'h01);
    rdc("ecom on", ma(1, SUB_MODE), 8'h4C);
    wr(OFF_CNT_LO, 8'hF0);
    wr(OFF_CNT_HI, 8'h00);
    chk("hso idle", {15'h0, pin_o[1]}, 16'h0);
    wr(OFF_CTRL, 8'h40);
    wait_flip(1, n);
    chk("hso toggle", {15'h0, pin_o[1]}, 16'h1);
    rdc("match flag", OFF_CTRL, 8'h42);
    wr(ma(2, SUB_MODE), 8'h42);
    wr(ma(2, SUB_CMP_LO), 8'h80);
    wr(ma(2, SUB_CMP_HI), 8'h80);
    repeat (300) @(posedge aclk);
    hi_count(2, n);
    chk("pwm8 half", 16'(n), 16'd128);
    wr(ma(2, SUB_CMP_HI), 8'hC0);
    repeat (300) @(posedge aclk);
    hi_count(2, n);
    chk("pwm8 reload", 16'(n), 16'd64);
    wr(ma(2, SUB_CMP_LO), 8'h00);
    hi_count(2, n);
    chk("pwm8 off", 16'(n), 16'd0);
    wr(ma(3, SUB_MODE), 8'h46);
    wr(ma(3, SUB_CMP_LO), 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(ma(3, SUB_CMP_HI), hv[k]);
      wait_flip(3, n);
      wait_flip(3, n);
      chk("square half", 16'(n), 16'(per[k]));
    end
    // A 16-bit compare near the top of the count keeps the wide pulse test short.
    wr(ma(4, SUB_MODE), 8'hCB);
    wr(ma(4, SUB_CMP_LO), 8'h00);
    wr(ma(4, SUB_CMP_HI), 8'hFF);
    wr(OFF_CNT_LO, 8'h00);
    wr(OFF_CNT_HI, 8'hFE);
    wait_flip(4, n);
    chk("pwm16 high", {15'h0, pin_o[4]}, 16'h1);
    wait_flip(4, n);
    chk("pwm16 low", 16'(n), 16'd256);
    rdc("pwm16 flags", OFF_CTRL, 8'hD2);
    chk("pwm16 irq", {15'h0, irq}, 16'h1);
    close_out();
  end
endmodule : cca_array_tb
`default_nettype wire
